// >>> pfx_consts.svh
`ifndef PFX_CONSTS_SVH
`define PFX_CONSTS_SVH
// byte offsets
`define PFX_OFF_PHY_ACCESS 8'h24
`define PFX_OFF_ASYNC_TX_FIFO_STATUS 8'h30
`define PFX_OFF_TEST_PORT 8'h80
// reset values
`define PFX_PHY_ACCESS_RST 32'h0000_0000
`define PFX_ASYNC_TX_FIFO_STATUS_RST 32'h0000_0000
// phy access fields, lsb index of msb-0 numbering converted to verilog bit index
`define PFX_RD_REQ_BIT 31
`define PFX_WR_REQ_BIT 30
`define PFX_TGT_ADDR_LSB 24
`define PFX_WR_VAL_LSB 16
`define PFX_RX_ADDR_LSB 8
`define PFX_RX_VAL_LSB 0
// async_tx_fifo_status fields
`define PFX_FULL_BIT 31
`define PFX_EMPTY_BIT 30
`define PFX_MISMATCH_BIT 29
`define PFX_PTR_CLR_BIT 28
`define PFX_MARKER_BIT 27
`define PFX_TEST_MODE_BIT 26
`define PFX_PTR_LSB 17
`define PFX_SPACE_LSB 0
`endif

// >>> pfx_pkg.sv
package pfx_pkg;
   typedef struct packed {
      logic wr;
      logic [3:0] addr;
      logic [7:0] data;
   } pfx_phy_req_type;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
   } pfx_phy_rsp_type;
   typedef enum logic [1:0] {PFX_REQ_NONE, PFX_REQ_RD, PFX_REQ_WR} pfx_req_kind_type;
endpackage : pfx_pkg

// >>> pfx_fifo_ram.sv
`timescale 1ns/1ps
module pfx_fifo_ram #(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [32:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [32:0] o_rdata
);
   // 33-bit entries, marker in bit 32
   logic [32:0] mem [DEPTH];
   assign o_rdata = mem[i_raddr];
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end
endmodule : pfx_fifo_ram

// >>> pfx_regs.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "pfx_consts.svh"
module pfx_regs
   import pfx_pkg::*;
#(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic i_clk,
   input wire logic i_rst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // phy register request port
   output logic o_phy_req_valid,
   output pfx_phy_req_type o_phy_req,
   input wire logic i_phy_req_ready,
   // phy register response
   input wire logic i_phy_rsp_valid,
   input wire pfx_phy_rsp_type i_phy_rsp,
   output logic o_phy_info_received_irq,
   // transmit queue push from host data port
   input wire logic i_queue_wr,
   input wire logic [32:0] i_queue_wdata,
   // transmit queue pop from transmitter
   input wire logic i_queue_rd,
   output logic [32:0] o_queue_rdata,
   output logic o_queue_empty
);
   logic phy_read_request_r, phy_read_request_nxt;
   logic phy_write_request_r, phy_write_request_nxt;
   logic [3:0] phy_target_reg_addr_r, phy_target_reg_addr_nxt;
   logic [7:0] phy_write_value_r, phy_write_value_nxt;
   logic [3:0] phy_returned_reg_addr_r, phy_returned_reg_addr_nxt;
   logic [7:0] phy_returned_value_r, phy_returned_value_nxt;
   logic irq_r, irq_nxt;
   logic req_valid_r, req_valid_nxt;
   pfx_phy_req_type req_r, req_nxt;
   logic marker_mismatch_flag_r, marker_mismatch_flag_nxt;
   logic test_pointer_clear_r, test_pointer_clear_nxt;
   logic marker_ctl_r, marker_ctl_nxt;
   logic memory_test_mode_r, memory_test_mode_nxt;
   logic [AW-1:0] test_pointer_r, test_pointer_nxt;
   logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [AW:0] count_r, count_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [32:0] qdata_r, qdata_nxt;
   logic empty_r, empty_nxt;
   logic ram_we;
   logic [AW-1:0] ram_waddr, ram_raddr, acc_ptr;
   logic [32:0] ram_wdata, ram_rdata;
   logic acc, wr_acc, rd_acc, test_acc, full, push, pop;
   logic [AW:0] space;

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : is_reg

   assign acc = i_psel && i_penable && !pready_r;
   assign wr_acc = acc && i_pwrite;
   assign rd_acc = acc && !i_pwrite;
   assign test_acc = acc && memory_test_mode_r && is_reg(i_paddr, `PFX_OFF_TEST_PORT);
   assign full = count_r == (AW+1)'(DEPTH);
   assign space = (AW+1)'(DEPTH) - count_r;
   // queue functions disabled in test mode
   assign push = i_queue_wr && !full && !memory_test_mode_r;
   assign pop = i_queue_rd && count_r != '0 && !memory_test_mode_r;
   // pointer clear lets this access hit location 0
   assign acc_ptr = test_pointer_clear_r ? '0 : test_pointer_r;
   // storage used as plain memory in test mode
   assign ram_we = memory_test_mode_r ? (test_acc && i_pwrite) : push;
   assign ram_waddr = memory_test_mode_r ? acc_ptr : wptr_r;
   assign ram_wdata = memory_test_mode_r ? {marker_ctl_r, i_pwdata} : i_queue_wdata;
   assign ram_raddr = memory_test_mode_r ? acc_ptr : rptr_r;

   pfx_fifo_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
      .i_clk(i_clk),
      .i_we(ram_we),
      .i_waddr(ram_waddr),
      .i_wdata(ram_wdata),
      .i_raddr(ram_raddr),
      .o_rdata(ram_rdata)
   );

   // phy access register and request sequencing
   always_comb begin
      phy_read_request_nxt = phy_read_request_r;
      phy_write_request_nxt = phy_write_request_r;
      phy_target_reg_addr_nxt = phy_target_reg_addr_r;
      phy_write_value_nxt = phy_write_value_r;
      phy_returned_reg_addr_nxt = phy_returned_reg_addr_r;
      phy_returned_value_nxt = phy_returned_value_r;
      irq_nxt = irq_r;
      req_valid_nxt = req_valid_r;
      req_nxt = req_r;
      if (req_valid_r && i_phy_req_ready) begin
         req_valid_nxt = 1'b0;
         // bit clears once its request has gone out
         if (req_r.wr) begin
            phy_write_request_nxt = 1'b0;
         end else begin
            phy_read_request_nxt = 1'b0;
         end
      end
      if (!req_valid_nxt) begin
         // read served first, write follows
         if (phy_read_request_nxt) begin
            req_valid_nxt = 1'b1;
            req_nxt = '{wr: 1'b0, addr: phy_target_reg_addr_nxt, data: phy_write_value_nxt};
         end else if (phy_write_request_nxt) begin
            req_valid_nxt = 1'b1;
            req_nxt = '{wr: 1'b1, addr: phy_target_reg_addr_nxt, data: phy_write_value_nxt};
         end
      end
      if (wr_acc && is_reg(i_paddr, `PFX_OFF_PHY_ACCESS)) begin
         // upper half request fields
         phy_read_request_nxt = phy_read_request_nxt | i_pwdata[`PFX_RD_REQ_BIT];
         phy_write_request_nxt = phy_write_request_nxt | i_pwdata[`PFX_WR_REQ_BIT];
         phy_target_reg_addr_nxt = i_pwdata[`PFX_TGT_ADDR_LSB +: 4];
         phy_write_value_nxt = i_pwdata[`PFX_WR_VAL_LSB +: 8];
      end
      irq_nxt = 1'b0;
      if (i_phy_rsp_valid) begin
         phy_returned_reg_addr_nxt = i_phy_rsp.addr;
         phy_returned_value_nxt = i_phy_rsp.data;
         irq_nxt = 1'b1;
      end
   end

   // transmit queue pointers and test-mode state
   always_comb begin
      marker_mismatch_flag_nxt = marker_mismatch_flag_r;
      test_pointer_clear_nxt = test_pointer_clear_r;
      marker_ctl_nxt = marker_ctl_r;
      memory_test_mode_nxt = memory_test_mode_r;
      test_pointer_nxt = test_pointer_r;
      wptr_nxt = push ? AW'(wptr_r + 1'b1) : wptr_r;
      rptr_nxt = pop ? AW'(rptr_r + 1'b1) : rptr_r;
      count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
      qdata_nxt = ram_rdata;
      empty_nxt = count_nxt == '0;
      if (wr_acc && is_reg(i_paddr, `PFX_OFF_ASYNC_TX_FIFO_STATUS)) begin
         // only control bits are writable
         marker_ctl_nxt = i_pwdata[`PFX_MARKER_BIT];
         memory_test_mode_nxt = i_pwdata[`PFX_TEST_MODE_BIT];
         test_pointer_clear_nxt = test_pointer_clear_r | i_pwdata[`PFX_PTR_CLR_BIT];
         if (i_pwdata[`PFX_PTR_CLR_BIT] || !i_pwdata[`PFX_TEST_MODE_BIT]) begin
            marker_mismatch_flag_nxt = 1'b0;
         end
      end
      if (test_acc) begin
         test_pointer_nxt = AW'(acc_ptr + 1'b1);
         test_pointer_clear_nxt = 1'b0;
         if (test_pointer_clear_r) begin
            marker_mismatch_flag_nxt = 1'b0;
         end
         if (!i_pwrite && ram_rdata[32] != marker_ctl_r) begin
            marker_mismatch_flag_nxt = 1'b1;
         end
      end
   end

   // apb read mux, one wait state
   always_comb begin
      prdata_nxt = '0;
      pready_nxt = acc;
      pslverr_nxt = 1'b0;
      if (rd_acc) begin
         if (is_reg(i_paddr, `PFX_OFF_PHY_ACCESS)) begin
            prdata_nxt[`PFX_RD_REQ_BIT] = phy_read_request_r;
            prdata_nxt[`PFX_WR_REQ_BIT] = phy_write_request_r;
            prdata_nxt[`PFX_TGT_ADDR_LSB +: 4] = phy_target_reg_addr_r;
            prdata_nxt[`PFX_WR_VAL_LSB +: 8] = phy_write_value_r;
            prdata_nxt[`PFX_RX_ADDR_LSB +: 4] = phy_returned_reg_addr_r;
            prdata_nxt[`PFX_RX_VAL_LSB +: 8] = phy_returned_value_r;
         end else if (is_reg(i_paddr, `PFX_OFF_ASYNC_TX_FIFO_STATUS)) begin
            prdata_nxt[`PFX_FULL_BIT] = full;
            prdata_nxt[`PFX_EMPTY_BIT] = count_r == '0;
            prdata_nxt[`PFX_MISMATCH_BIT] = marker_mismatch_flag_r;
            prdata_nxt[`PFX_PTR_CLR_BIT] = test_pointer_clear_r;
            prdata_nxt[`PFX_MARKER_BIT] = marker_ctl_r;
            prdata_nxt[`PFX_TEST_MODE_BIT] = memory_test_mode_r;
            prdata_nxt[`PFX_PTR_LSB +: AW] = test_pointer_r;
            prdata_nxt[`PFX_SPACE_LSB +: AW] = space[AW-1:0];
         end else if (test_acc) begin
            prdata_nxt = ram_rdata[31:0];
         end else begin
            pslverr_nxt = acc;
         end
      end else if (wr_acc) begin
         pslverr_nxt = !(is_reg(i_paddr, `PFX_OFF_PHY_ACCESS) || is_reg(i_paddr, `PFX_OFF_ASYNC_TX_FIFO_STATUS) || test_acc);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         // all registers start at zero except empty_r, which starts at one
         phy_read_request_r <= 1'b0;
         phy_write_request_r <= 1'b0;
         phy_target_reg_addr_r <= '0;
         phy_write_value_r <= '0;
         phy_returned_reg_addr_r <= '0;
         phy_returned_value_r <= '0;
         irq_r <= 1'b0;
         req_valid_r <= 1'b0;
         req_r <= '0;
         marker_mismatch_flag_r <= 1'b0;
         test_pointer_clear_r <= 1'b0;
         marker_ctl_r <= 1'b0;
         memory_test_mode_r <= 1'b0;
         test_pointer_r <= '0;
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
         qdata_r <= '0;
         empty_r <= 1'b1;
         prdata_r <= '0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         phy_read_request_r <= phy_read_request_nxt;
         phy_write_request_r <= phy_write_request_nxt;
         phy_target_reg_addr_r <= phy_target_reg_addr_nxt;
         phy_write_value_r <= phy_write_value_nxt;
         phy_returned_reg_addr_r <= phy_returned_reg_addr_nxt;
         phy_returned_value_r <= phy_returned_value_nxt;
         irq_r <= irq_nxt;
         req_valid_r <= req_valid_nxt;
         req_r <= req_nxt;
         marker_mismatch_flag_r <= marker_mismatch_flag_nxt;
         test_pointer_clear_r <= test_pointer_clear_nxt;
         marker_ctl_r <= marker_ctl_nxt;
         memory_test_mode_r <= memory_test_mode_nxt;
         test_pointer_r <= test_pointer_nxt;
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         count_r <= count_nxt;
         qdata_r <= qdata_nxt;
         empty_r <= empty_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_phy_req_valid = req_valid_r;
   assign o_phy_req = req_r;
   assign o_phy_info_received_irq = irq_r;
   assign o_queue_rdata = qdata_r;
   assign o_queue_empty = empty_r;
endmodule : pfx_regs

// >>> pfx_phy_model.sv
`timescale 1ns/1ps
module pfx_phy_model
   import pfx_pkg::*;
(
   // clock
   input wire logic i_clk,
   // request side
   input wire logic i_req_valid,
   input wire pfx_phy_req_type i_req,
   output logic o_req_ready,
   // response side
   output logic o_rsp_valid,
   output pfx_phy_rsp_type o_rsp
);
   logic [7:0] mem [0:15];
   pfx_phy_req_type seen [$];
   int stall;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
      o_req_ready = 1'b0;
      o_rsp_valid = 1'b0;
      o_rsp = '0;
      stall = 0;
   end
   // ready comes after one or two idle cycles, never at once
   always @(posedge i_clk) begin
      o_rsp_valid <= 1'b0;
      o_req_ready <= 1'b0;
      o_rsp <= ~o_rsp;
      if (i_req_valid && o_req_ready) begin
         seen.push_back(i_req);
         if (i_req.wr) begin
            mem[i_req.addr] <= i_req.data;
         end else begin
            o_rsp_valid <= 1'b1;
            o_rsp <= '{addr: i_req.addr, data: mem[i_req.addr]};
         end
      end else if (i_req_valid) begin
         stall <= stall + 1;
         o_req_ready <= (stall % 3 != 0);
      end
   end
endmodule : pfx_phy_model

// >>> pfx_regs_assertions.sv
`timescale 1ns/1ps
module pfx_regs_assertions
   import pfx_pkg::*;
#(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_phy_req_valid,
   input wire pfx_phy_req_type o_phy_req,
   input wire logic i_phy_req_ready,
   input wire logic i_phy_rsp_valid,
   input wire logic o_phy_info_received_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence take_s;
      i_psel && i_penable && !o_pready;
   endsequence
   sequence rd_req_take_s;
      take_s ##0 (i_pwrite && i_paddr == 8'h24 && i_pwdata[31] && !o_phy_req_valid);
   endsequence
   wire mapped = i_paddr == 8'h24 || i_paddr == 8'h30 || i_paddr == 8'h80;
   a_ready_answer: assert property (take_s |=> o_pready) else $error("no ready after take");
   a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
   a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable)) else $error("ready without access");
   a_unmapped_err: assert property ((take_s ##0 !mapped) |=> o_pslverr) else $error("unmapped not refused");
   a_err_rd_zero: assert property (o_pslverr && !$past(i_pwrite) |-> o_prdata == 32'h0) else $error("refused read nonzero");
   a_req_launch: assert property (rd_req_take_s |-> ##[1:3] o_phy_req_valid) else $error("read request not issued");
   a_req_hold: assert property (o_phy_req_valid && !i_phy_req_ready |=> o_phy_req_valid && $stable(o_phy_req))
      else $error("request dropped before accept");
   a_irq_after: assert property (i_phy_rsp_valid |=> o_phy_info_received_irq) else $error("irq missing");
   a_irq_cause: assert property (o_phy_info_received_irq |-> $past(i_phy_rsp_valid)) else $error("stray irq");
endmodule : pfx_regs_assertions
bind pfx_regs pfx_regs_assertions #(.DEPTH(DEPTH), .AW(AW)) u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_phy_req_valid(o_phy_req_valid), .o_phy_req(o_phy_req),
   .i_phy_req_ready(i_phy_req_ready), .i_phy_rsp_valid(i_phy_rsp_valid),
   .o_phy_info_received_irq(o_phy_info_received_irq));

// >>> phy_access_and_tx_fifo_test_tb.sv
`timescale 1ns/1ps
module phy_access_and_tx_fifo_test_tb;
   import pfx_pkg::*;
   logic i_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, pready, perr, rv, rr, sv, irq, qwr = 0, qrd = 0, qe;
   logic [7:0] pa = '0;
   logic [31:0] pwd = '0, prd, rd;
   logic [32:0] qwd = '0, qrd_d;
   logic err;
   pfx_phy_req_type req;
   pfx_phy_rsp_type rsp;
   int n_errors = 0, checks = 0, irqs = 0;
   pfx_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
      .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(perr), .o_phy_req_valid(rv), .o_phy_req(req),
      .i_phy_req_ready(rr), .i_phy_rsp_valid(sv), .i_phy_rsp(rsp), .o_phy_info_received_irq(irq),
      .i_queue_wr(qwr), .i_queue_wdata(qwd), .i_queue_rd(qrd), .o_queue_rdata(qrd_d), .o_queue_empty(qe));
   pfx_phy_model u_phy (.i_clk(i_clk), .i_req_valid(rv), .i_req(req), .o_req_ready(rr), .o_rsp_valid(sv),
      .o_rsp(rsp));
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) if (irq === 1'b1) irqs++;
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge i_clk) pen <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         wrap_up();
      end
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      // idle cycle so a following call never re-drives psel in this time step
      @(posedge i_clk);
   endtask : apb
   task automatic phy_done();
      int n;
      n = 0;
      do begin
         apb(0, 8'h24, 0);
         n++;
      end while (rd[31:30] !== 2'b00 && n < 20);
      if (n >= 20) begin
         n_errors++;
         wrap_up();
      end
      repeat (4) @(posedge i_clk);
      apb(0, 8'h24, 0);
   endtask : phy_done
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      apb(0, 8'h24, 0);
      chk("access reset", 0, rd);
      apb(0, 8'h30, 0);
      chk("status ctl reset", 0, rd & 32'h3FFE_0000);
      chk("empty flag", 2'b01, rd[31:30]);
      apb(1, 8'h24, 32'h6A5A_FFFF);
      phy_done();
      chk("access after write", 32'h0A5A_0000, rd);
      chk("phy write seen", 13'h1A5A, u_phy.seen[0]);
      apb(1, 8'h24, 32'hC3C3_0000);
      phy_done();
      chk("read first", 13'h0300, u_phy.seen[1] & 13'h1F00);
      chk("write second", 13'h13C3, u_phy.seen[2]);
      chk("returned fields", 12'h313, rd[11:0]);
      chk("irq count", 1, irqs);
      apb(1, 8'h24, 32'h8A00_0000);
      phy_done();
      chk("returned written", 12'hA5A, rd[11:0]);
      chk("irq count two", 2, irqs);
      for (int i = 0; i < 513; i++) begin
         qwr <= 1'b1;
         qwd <= (i == 512) ? 33'h1_FFFF_FFFF : {i == 0, 32'(i)};
         @(posedge i_clk);
      end
      qwr <= 1'b0;
      apb(0, 8'h30, 0);
      chk("full flags", 2'b10, rd[31:30]);
      chk("space zero", 0, rd[8:0]);
      apb(1, 8'h30, 32'hE000_0000);
      apb(0, 8'h30, 0);
      chk("flags read only", 3'b100, rd[31:29]);
      for (int i = 0; i < 512; i++) begin
         chk("queue head", {i == 0, 32'(i)}, qrd_d);
         qrd <= 1'b1;
         @(posedge i_clk) qrd <= 1'b0;
         repeat (2) @(posedge i_clk);
      end
      chk("drained", 1, qe);
      apb(0, 8'h80, 0);
      chk("test port off", 1, err);
      apb(1, 8'h30, 32'h0400_0000);
      apb(1, 8'h30, 32'h1C00_0000);
      for (int i = 0; i < 4; i++) apb(1, 8'h80, 32'hD0 + i);
      qwr <= 1'b1;
      @(posedge i_clk) qwr <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk("queue off in test", 1, qe);
      apb(0, 8'h30, 0);
      chk("pointer four", 4, rd[25:17]);
      chk("control bits", 3'b011, rd[28:26]);
      apb(1, 8'h30, 32'h1C00_0000);
      for (int i = 0; i < 4; i++) begin
         apb(0, 8'h80, 0);
         chk("test readback", 32'hD0 + i, rd);
      end
      apb(0, 8'h30, 0);
      chk("no mismatch", 0, rd[29]);
      apb(1, 8'h30, 32'h1400_0000);
      apb(0, 8'h80, 0);
      apb(0, 8'h30, 0);
      chk("mismatch set", 1, rd[29]);
      chk("pointer one", 1, rd[25:17]);
      apb(1, 8'h30, 0);
      apb(0, 8'h30, 0);
      chk("mismatch cleared", 0, rd[29]);
      apb(1, 8'h44, 32'hFFFF_FFFF);
      chk("unmapped write err", 1, err);
      apb(0, 8'h44, 0);
      chk("unmapped read", 33'h1_0000_0000, {err, rd});
      // second reset with state loaded in both registers
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      apb(0, 8'h24, 0);
      chk("access second reset", 0, rd);
      apb(0, 8'h30, 0);
      chk("status ctl second reset", 0, rd & 32'h3FFE_0000);
      wrap_up();
   end
endmodule : phy_access_and_tx_fifo_test_tb
